// *** design/gpa_top.sv ***
// Transceiver attachment: management slave, link bring-up, indicators and clock delay control.
// Assumes management pins and straps arrive asynchronously and frame strobes on the link clock.
`timescale 1ns/1ps

module gpa_link_mon (
  input wire logic i_link_clk,
  input wire logic i_rst_b,
  input wire logic i_link_rx_dv,
  input wire logic i_link_tx_en,
  output logic o_act_tgl
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic rx_q;
    logic tx_q;
    logic tgl;
  } gpa_lm_s;
  gpa_lm_s q;
  gpa_lm_s n;

  always_comb begin
    n = q;
    n.rst_s1 = i_rst_b;
    n.rst_s2 = q.rst_s1;
    n.rx_q = i_link_rx_dv;
    n.tx_q = i_link_tx_en;
    // A toggle per frame start lets the event cross even if this clock stops afterwards.
    if ((i_link_rx_dv && !q.rx_q) || (i_link_tx_en && !q.tx_q)) begin
      n.tgl = !q.tgl;
    end
    if (!q.rst_s2) begin
      n.rx_q = 1'b0;
      n.tx_q = 1'b0;
      n.tgl = 1'b0;
    end
  end

  always_ff @(posedge i_link_clk) begin
    q <= n;
  end

  assign o_act_tgl = q.tgl;
endmodule

module gpa_top import gpa_pkg::*; #(
  parameter int AN_CYCLES = AN_CYC,
  parameter int EEE_ON_CYCLES = EEE_ON_CYC,
  parameter int EEE_OFF_CYCLES = EEE_OFF_CYC,
  parameter int ACT_HALF_CYCLES = ACT_HALF_CYC,
  parameter logic [15:0] PHY_ID1 = 16'h1234, // Arbitrary identity value.
  parameter logic [15:0] PHY_ID2 = 16'h5670  // Arbitrary identity value.
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_link_clk,
  input wire logic i_link_rx_dv,
  input wire logic i_link_tx_en,
  input wire logic i_partner_present,
  input wire logic i_eee_active,
  input wire logic i_phy_reset_n,
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe_n,
  output logic o_phy_irq_n,
  output logic o_link_up,
  output logic o_link_led,
  output logic o_act_led,
  output logic o_txc_delay_en,
  output logic o_rxc_delay_en
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    logic part_s1;
    logic part_s2;
    logic eee_s1;
    logic eee_s2;
    logic act_s1;
    logic act_s2;
    logic act_s3;
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [15:0] gctrl;
    logic [15:0] irq_en;
    logic [15:0] irq_st;
    logic [15:0] dly;
    logic link_up;
    logic link_latch;
    logic an_done;
    logic [31:0] an_cnt;
    logic [31:0] blink_cnt;
    logic blink_on;
    logic [31:0] act_cnt;
    logic link_led;
    logic act_led;
    gpa_mdio_e mst;
    logic [5:0] bit_cnt;
    logic [15:0] shreg;
    logic rd_hit;
    logic wr_hit;
    logic [4:0] reg_addr;
    logic mdio_o;
    logic mdio_oe_n;
    logic irq_n;
  } gpa_top_s;

  localparam gpa_top_s TOP_RST = '{ctrl: CTRL_RST, adv: ADV_RST, gctrl: GCTRL_RST, irq_en: IRQ_EN_RST,
                                   dly: DELAY_RST, blink_on: 1'b1, mst: MS_IDLE, mdio_oe_n: 1'b1,
                                   irq_n: 1'b1, default: '0};

  gpa_top_s q;
  gpa_top_s n;
  logic act_tgl;

  gpa_link_mon u_link_mon (
    .i_link_clk(i_link_clk),
    .i_rst_b(i_rst_b),
    .i_link_rx_dv(i_link_rx_dv),
    .i_link_tx_en(i_link_tx_en),
    .o_act_tgl(act_tgl)
  );

  function automatic logic [15:0] reg_read(input gpa_top_s s, input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == REG_CTRL) begin
      v = s.ctrl;
    end else if (a == REG_STAT) begin
      v = STAT_FIXED;
      v[STAT_AN_DONE_BIT] = s.an_done;
      v[STAT_LINK_BIT] = s.link_latch;
    end else if (a == REG_ID1) begin
      v = PHY_ID1;
    end else if (a == REG_ID2) begin
      v = PHY_ID2;
    end else if (a == REG_ADV) begin
      v = s.adv;
    end else if (a == REG_PARTNER) begin
      v = s.link_up ? PARTNER_UP : 16'h0000;
    end else if (a == REG_GCTRL) begin
      v = s.gctrl;
    end else if (a == REG_GSTAT) begin
      v = s.link_up ? GSTAT_UP : 16'h0000;
    end else if (a == REG_IRQ_EN) begin
      v = s.irq_en;
    end else if (a == REG_IRQ_STAT) begin
      v = s.irq_st;
    end else if (a == REG_DELAY) begin
      v = s.dly;
    end
    return v;
  endfunction

  always_comb begin
    logic mdc_rise;
    logic bit_in;
    logic [15:0] sh_in;
    logic [15:0] irq_set;
    logic [15:0] irq_clr;
    logic soft_rst;
    logic restart;
    logic act_evt;
    mdc_rise = 1'b0;
    bit_in = 1'b0;
    sh_in = 16'h0000;
    irq_set = 16'h0000;
    irq_clr = 16'h0000;
    soft_rst = 1'b0;
    restart = 1'b0;
    act_evt = 1'b0;
    n = q;
    n.rst_s1 = i_phy_reset_n;
    n.rst_s2 = q.rst_s1;
    n.mdc_s1 = i_mdc;
    n.mdc_s2 = q.mdc_s1;
    n.mdc_s3 = q.mdc_s2;
    n.mdio_s1 = i_mdio;
    n.mdio_s2 = q.mdio_s1;
    n.part_s1 = i_partner_present;
    n.part_s2 = q.part_s1;
    n.eee_s1 = i_eee_active;
    n.eee_s2 = q.eee_s1;
    n.act_s1 = act_tgl;
    n.act_s2 = q.act_s1;
    n.act_s3 = q.act_s2;
    mdc_rise = q.mdc_s2 && !q.mdc_s3;
    bit_in = q.mdio_s2;
    sh_in = {q.shreg[14:0], bit_in};
    act_evt = q.act_s2 ^ q.act_s3;
    if (!q.link_up) begin
      n.link_latch = 1'b0;
    end

    // Management frame slave; drives the data line just after each rising clock edge.
    if (mdc_rise) begin
      case (q.mst)
        MS_IDLE: begin
          if (bit_in) begin
            n.bit_cnt = (q.bit_cnt == PRE_ONES) ? q.bit_cnt : q.bit_cnt + 6'h01;
          end else begin
            n.mst = (q.bit_cnt == PRE_ONES) ? MS_HDR : MS_IDLE;
            n.bit_cnt = 6'h00;
          end
        end
        MS_HDR: begin
          n.shreg = sh_in;
          n.bit_cnt = q.bit_cnt + 6'h01;
          if (q.bit_cnt == HDR_LAST) begin
            n.mst = MS_TA;
            n.bit_cnt = 6'h00;
            n.reg_addr = sh_in[4:0];
            n.rd_hit = sh_in[12] && (sh_in[9:5] == PHY_ADDR) && (sh_in[11:10] == OP_READ);
            n.wr_hit = sh_in[12] && (sh_in[9:5] == PHY_ADDR) && (sh_in[11:10] == OP_WRITE);
          end
        end
        MS_TA: begin
          n.bit_cnt = 6'h01;
          if (q.bit_cnt == 6'h00) begin
            if (q.rd_hit) begin
              n.mdio_oe_n = 1'b0;
              n.mdio_o = 1'b0;
              n.shreg = reg_read(q, q.reg_addr);
              if (q.reg_addr == REG_IRQ_STAT) begin
                irq_clr = q.irq_st;
              end
              if (q.reg_addr == REG_STAT) begin
                n.link_latch = q.link_up;
              end
            end
          end else begin
            n.mst = MS_DATA;
            n.bit_cnt = 6'h00;
            if (q.rd_hit) begin
              n.mdio_o = q.shreg[15];
              n.shreg = {q.shreg[14:0], 1'b0};
            end
          end
        end
        MS_DATA: begin
          n.bit_cnt = q.bit_cnt + 6'h01;
          n.shreg = q.rd_hit ? {q.shreg[14:0], 1'b0} : sh_in;
          n.mdio_o = q.shreg[15];
          if (q.bit_cnt == DATA_LAST) begin
            n.mst = MS_IDLE;
            n.bit_cnt = 6'h00;
            n.mdio_oe_n = 1'b1;
            n.mdio_o = 1'b0;
            n.rd_hit = 1'b0;
            n.wr_hit = 1'b0;
            if (q.wr_hit) begin
              if (q.reg_addr == REG_CTRL) begin
                n.ctrl = sh_in;
                n.ctrl[CTRL_AN_RESTART_BIT] = 1'b0;
                n.ctrl[CTRL_RESET_BIT] = 1'b0;
                restart = sh_in[CTRL_AN_RESTART_BIT];
                soft_rst = sh_in[CTRL_RESET_BIT];
              end else if (q.reg_addr == REG_ADV) begin
                n.adv = sh_in;
              end else if (q.reg_addr == REG_GCTRL) begin
                n.gctrl = sh_in;
              end else if (q.reg_addr == REG_IRQ_EN) begin
                n.irq_en = sh_in;
              end else if (q.reg_addr == REG_DELAY) begin
                n.dly = sh_in;
              end
            end
          end
        end
        default: begin
          n.mst = MS_IDLE;
        end
      endcase
    end

    // Bring-up runs from power-up defaults alone; no host access is needed.
    if (!q.part_s2 || restart) begin
      n.link_up = 1'b0;
      n.an_done = 1'b0;
      n.an_cnt = 32'h0000_0000;
    end else if (!q.ctrl[CTRL_AN_EN_BIT]) begin
      n.link_up = 1'b1;
    end else if (!q.an_done) begin
      n.an_cnt = q.an_cnt + 32'h0000_0001;
      if (q.an_cnt >= 32'(AN_CYCLES - 1)) begin
        n.an_done = 1'b1;
        n.link_up = 1'b1;
      end
    end
    irq_set[IRQ_LINK_BIT] = n.link_up != q.link_up;
    irq_set[IRQ_AN_BIT] = n.an_done && !q.an_done;
    // A new event in the cycle of a clearing read survives it.
    n.irq_st = (q.irq_st & ~irq_clr) | irq_set;
    n.irq_n = ~|(n.irq_st & q.irq_en);

    // Link lamp: steady, or a slow on/off cadence while the link saves energy.
    if (q.link_up && q.eee_s2) begin
      n.blink_cnt = q.blink_cnt + 32'h0000_0001;
      if (q.blink_on && q.blink_cnt >= 32'(EEE_ON_CYCLES - 1)) begin
        n.blink_on = 1'b0;
        n.blink_cnt = 32'h0000_0000;
      end else if (!q.blink_on && q.blink_cnt >= 32'(EEE_OFF_CYCLES - 1)) begin
        n.blink_on = 1'b1;
        n.blink_cnt = 32'h0000_0000;
      end
    end else begin
      n.blink_cnt = 32'h0000_0000;
      n.blink_on = 1'b1;
    end
    n.link_led = q.link_up && q.blink_on;

    // A frame start with the link up and no flash running yields one on/off flash; steady traffic keeps it flashing.
    if (q.act_cnt != 32'h0000_0000) begin
      n.act_cnt = q.act_cnt - 32'h0000_0001;
    end else if (act_evt && q.link_up) begin
      n.act_cnt = 32'(2 * ACT_HALF_CYCLES);
    end
    n.act_led = q.act_cnt > 32'(ACT_HALF_CYCLES);

    // The reset pin and the soft reset bit both return the registers, link state and management slave to power-up defaults; lamp timers keep running.
    if (!q.rst_s2 || soft_rst) begin
      n.ctrl = TOP_RST.ctrl;
      n.adv = TOP_RST.adv;
      n.gctrl = TOP_RST.gctrl;
      n.irq_en = TOP_RST.irq_en;
      n.irq_st = TOP_RST.irq_st;
      n.dly = TOP_RST.dly;
      n.link_up = 1'b0;
      n.link_latch = 1'b0;
      n.an_done = 1'b0;
      n.an_cnt = 32'h0000_0000;
      n.mst = MS_IDLE;
      n.bit_cnt = 6'h00;
      n.rd_hit = 1'b0;
      n.wr_hit = 1'b0;
      n.mdio_oe_n = 1'b1;
      n.mdio_o = 1'b0;
      n.irq_n = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q <= TOP_RST;
    end else if (i_ce) begin
      q <= n;
    end
  end

  assign o_mdio = q.mdio_o;
  assign o_mdio_oe_n = q.mdio_oe_n;
  assign o_phy_irq_n = q.irq_n;
  assign o_link_up = q.link_up;
  assign o_link_led = q.link_led;
  assign o_act_led = q.act_led;
  // The 2 ns skew itself is made by an analogue delay cell outside; these select it.
  assign o_txc_delay_en = q.dly[DELAY_TX_BIT];
  assign o_rxc_delay_en = q.dly[DELAY_RX_BIT];
endmodule

// *** design/gpa_pkg.sv ***
// Constants for the transceiver attachment block: management map, reset values and timing.
// Assumes a 200 MHz system clock; long counts are overridable at the top module.
package gpa_pkg;
  localparam int CLK_KHZ = 200000;
  localparam logic [4:0] PHY_ADDR = 5'h01;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  // Management register addresses.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID1 = 5'h02;
  localparam logic [4:0] REG_ID2 = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_PARTNER = 5'h05;
  localparam logic [4:0] REG_GCTRL = 5'h09;
  localparam logic [4:0] REG_GSTAT = 5'h0a;
  localparam logic [4:0] REG_IRQ_EN = 5'h12;
  localparam logic [4:0] REG_IRQ_STAT = 5'h13;
  localparam logic [4:0] REG_DELAY = 5'h14;
  // Reset values and fixed contents.
  localparam logic [15:0] CTRL_RST = 16'h1140;
  localparam logic [15:0] ADV_RST = 16'h0141;
  localparam logic [15:0] GCTRL_RST = 16'h0200;
  localparam logic [15:0] IRQ_EN_RST = 16'h0000;
  localparam logic [15:0] DELAY_RST = 16'h0003;
  localparam logic [15:0] STAT_FIXED = 16'h7909;
  localparam logic [15:0] PARTNER_UP = 16'h4141;
  localparam logic [15:0] GSTAT_UP = 16'h0800;
  // Field positions.
  localparam int CTRL_RESET_BIT = 15;
  localparam int CTRL_AN_EN_BIT = 12;
  localparam int CTRL_AN_RESTART_BIT = 9;
  localparam int STAT_AN_DONE_BIT = 5;
  localparam int STAT_LINK_BIT = 2;
  localparam int IRQ_LINK_BIT = 0;
  localparam int IRQ_AN_BIT = 1;
  localparam int DELAY_TX_BIT = 0;
  localparam int DELAY_RX_BIT = 1;
  // Timing.
  localparam int CLK_SKEW_PS = 2000;
  localparam int AN_TIME_US = 1000;
  localparam int EEE_ON_MS = 400;
  localparam int EEE_OFF_MS = 2000;
  localparam int ACT_HALF_MS = 40;
  localparam int AN_CYC = AN_TIME_US * CLK_KHZ / 1000;
  localparam int EEE_ON_CYC = EEE_ON_MS * CLK_KHZ;
  localparam int EEE_OFF_CYC = EEE_OFF_MS * CLK_KHZ;
  localparam int ACT_HALF_CYC = ACT_HALF_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_HDR = 2'b01,
    MS_TA = 2'b10,
    MS_DATA = 2'b11
  } gpa_mdio_e;
endpackage

// *** verification/gpa_top_monitor.sv ***
// Port-level checker for the transceiver attachment block.
// Assumes it is bound into gpa_top and sees only that module's ports.
`timescale 1ns/1ps
module gpa_top_mon #(
  parameter int EEE_ON_CYCLES = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_partner_present,
  input wire logic i_eee_active,
  input wire logic o_mdio,
  input wire logic o_mdio_oe_n,
  input wire logic o_phy_irq_n,
  input wire logic o_link_up,
  input wire logic o_link_led,
  input wire logic o_act_led,
  input wire logic o_txc_delay_en,
  input wire logic o_rxc_delay_en
);
  // The slack covers the two-flop sync on the energy-saving input.
  localparam int ON_MAX = EEE_ON_CYCLES + 6;
  logic [15:0] on_cnt_q;
  logic [15:0] on_cnt_d;
  always_comb begin
    on_cnt_d = '0;
    if (o_link_led && i_eee_active) begin
      on_cnt_d = on_cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      on_cnt_q <= '0;
    end else begin
      on_cnt_q <= on_cnt_d;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_absent;
    (!i_partner_present && i_ce)[*4];
  endsequence
  sequence s_steady_up;
    (o_link_up && !i_eee_active)[*4];
  endsequence
  a_reset_defaults: assert property (disable iff (1'b0) !i_rst_b |=> o_mdio_oe_n && o_phy_irq_n && !o_link_up
    && !o_act_led && o_txc_delay_en && o_rxc_delay_en) else $error("outputs not at reset values");
  a_link_drop: assert property (s_absent |=> !o_link_up) else $error("link stayed up");
  a_link_cause: assert property ($rose(o_link_up) |-> $past(i_partner_present, 3)) else $error("link without partner");
  a_lamp_off: assert property (!o_link_up |=> !o_link_led) else $error("link lamp lit without link");
  a_lamp_steady: assert property (s_steady_up |=> o_link_led) else $error("link lamp not steady");
  a_eee_blink: assert property (on_cnt_q <= ON_MAX) else $error("energy-saving on phase too long");
  a_act_link: assert property ($rose(o_act_led) |-> o_link_up || $past(o_link_up)) else $error("activity without link");
  a_act_flash: assert property ($rose(o_act_led) |=> o_act_led[*2]) else $error("activity flash too short");
  a_act_gap: assert property ($fell(o_act_led) |-> !o_act_led[*3]) else $error("activity gap too short");
  a_ta_zero: assert property ($fell(o_mdio_oe_n) |-> !o_mdio) else $error("turnaround not driven low");
  a_oe_bound: assert property ($fell(o_mdio_oe_n) |-> !o_mdio_oe_n[*8] ##[1:1000] o_mdio_oe_n)
    else $error("management line held too long");
endmodule
bind gpa_top gpa_top_mon #(.EEE_ON_CYCLES(EEE_ON_CYCLES)) u_mon (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
  .i_partner_present(i_partner_present), .i_eee_active(i_eee_active), .o_mdio(o_mdio), .o_mdio_oe_n(o_mdio_oe_n),
  .o_phy_irq_n(o_phy_irq_n), .o_link_up(o_link_up), .o_link_led(o_link_led), .o_act_led(o_act_led),
  .o_txc_delay_en(o_txc_delay_en), .o_rxc_delay_en(o_rxc_delay_en));

// *** verification/gpa_mac_model.sv ***
// Host MAC management master: sends whole management frames bit by bit.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module gpa_mac_model import gpa_pkg::*; (
  input wire logic i_clk,
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_en
);
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_en = 1'b0;
  end
  // The management period is 19 system clocks, well above the sync latency.
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
    output logic [15:0] rd);
    logic [63:0] fr;
    fr = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge i_clk);
      #1;
      o_mdc = 1'b0;
      o_mdio_en = !(op == OP_READ && i >= 46);
      o_mdio = fr[63-i];
      repeat (10) @(posedge i_clk);
      #1;
      o_mdc = 1'b1;
      if (i >= 48) rd = {rd[14:0], i_mdio};
      repeat (8) @(posedge i_clk);
    end
    @(posedge i_clk);
    #1;
    o_mdc = 1'b0;
    o_mdio_en = 1'b0;
  endtask
endmodule

// *** verification/test_gigabit_phy_attachment.sv ***
// Self-checking bench for the transceiver attachment block.
// Assumes the checker is bound in and the host MAC model drives management frames.
`timescale 1ns/1ps
module test_gigabit_phy_attachment;
  import gpa_pkg::*;
  localparam int AN = 20;
  localparam int W_LINK = 0;
  localparam int W_ACT = 1;
  localparam int W_IRQ = 2;
  logic clk = 1'b0, lclk = 1'b0, rst_b = 1'b0, ce = 1'b1, rx_dv = 1'b0, tx_en = 1'b0;
  logic partner = 1'b0, eee = 1'b0, phy_rst_n = 1'b0;
  logic m_mdc, m_mdio, m_en, d_mdio, d_oe_n, irq_n, link_up, link_led, act_led, txc_dly, rxc_dly, mdio_wire;
  logic [15:0] rd;
  int error_cnt = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  always #3 lclk = ~lclk;
  assign mdio_wire = m_en ? m_mdio : (d_oe_n ? 1'b1 : d_mdio);
  gpa_mac_model mac (.i_clk(clk), .i_mdio(mdio_wire), .o_mdc(m_mdc), .o_mdio(m_mdio), .o_mdio_en(m_en));
  gpa_top #(.AN_CYCLES(AN), .EEE_ON_CYCLES(8), .EEE_OFF_CYCLES(40), .ACT_HALF_CYCLES(4)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_link_clk(lclk), .i_link_rx_dv(rx_dv), .i_link_tx_en(tx_en),
    .i_partner_present(partner), .i_eee_active(eee), .i_phy_reset_n(phy_rst_n), .i_mdc(m_mdc),
    .i_mdio(mdio_wire), .o_mdio(d_mdio), .o_mdio_oe_n(d_oe_n), .o_phy_irq_n(irq_n), .o_link_up(link_up),
    .o_link_led(link_led), .o_act_led(act_led), .o_txc_delay_en(txc_dly), .o_rxc_delay_en(rxc_dly));
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function automatic logic probe(input int which);
    if (which == W_LINK) begin
      return link_up;
    end else if (which == W_ACT) begin
      return act_led;
    end
    return irq_n;
  endfunction
  task automatic wait_val(input int which, input logic val, output int n);
    for (n = 0; n < 200 && probe(which) !== val; n++) tick(1);
    check(16'(probe(which)), 16'(val));
    if (probe(which) !== val) complete_run();
  endtask
  task automatic t_defaults();
    check(16'({d_oe_n, irq_n, link_up, txc_dly, rxc_dly}), 16'h001b);
    mac.xfer(OP_READ, PHY_ADDR, REG_CTRL, 16'h0000, rd);
    check(rd, CTRL_RST);
    mac.xfer(OP_READ, PHY_ADDR, REG_ADV, 16'h0000, rd);
    check(rd, ADV_RST);
    mac.xfer(OP_READ, 5'h02, REG_CTRL, 16'h0000, rd);
    check(rd, 16'hffff);
  endtask
  task automatic t_link();
    int n;
    partner = 1'b1;
    wait_val(W_LINK, 1'b1, n);
    check(16'(n >= AN), 16'h0001);
    tick(2);
    check(16'(link_led), 16'h0001);
    mac.xfer(OP_READ, PHY_ADDR, REG_STAT, 16'h0000, rd);
    check(16'(rd[STAT_AN_DONE_BIT]), 16'h0001);
    // With the clock enable low the link must stay frozen even though the partner has left.
    ce = 1'b0;
    partner = 1'b0;
    tick(8);
    check(16'(link_up), 16'h0001);
    ce = 1'b1;
    wait_val(W_LINK, 1'b0, n);
    partner = 1'b1;
    wait_val(W_LINK, 1'b1, n);
  endtask
  task automatic t_act(input logic use_tx);
    int n;
    @(posedge lclk);
    #1;
    if (use_tx) tx_en = 1'b1; else rx_dv = 1'b1;
    // The flash is short, so it is watched while the frame is still running.
    wait_val(W_ACT, 1'b1, n);
    wait_val(W_ACT, 1'b0, n);
    check(16'(link_led), 16'h0001);
    @(posedge lclk);
    #1;
    tx_en = 1'b0;
    rx_dv = 1'b0;
    // A frame start that lands while the flash counter still runs would be absorbed.
    tick(8);
  endtask
  task automatic t_irq();
    int n;
    mac.xfer(OP_WRITE, PHY_ADDR, REG_IRQ_EN, 16'h0003, rd);
    tick(2);
    check(16'(irq_n), 16'h0000);
    mac.xfer(OP_READ, PHY_ADDR, REG_IRQ_STAT, 16'h0000, rd);
    check(rd, 16'h0003);
    check(16'(irq_n), 16'h0001);
    partner = 1'b0;
    wait_val(W_IRQ, 1'b0, n);
    partner = 1'b1;
    wait_val(W_LINK, 1'b1, n);
    mac.xfer(OP_READ, PHY_ADDR, REG_IRQ_STAT, 16'h0000, rd);
    check(rd, 16'h0003);
    check(16'(irq_n), 16'h0001);
  endtask
  task automatic t_eee();
    int on_n;
    int off_n;
    on_n = 0;
    off_n = 0;
    eee = 1'b1;
    for (int i = 0; i < 96; i++) begin
      tick(1);
      if (link_led) on_n++; else off_n++;
    end
    check(16'(on_n > 0 && off_n > 2 * on_n), 16'h0001);
    eee = 1'b0;
    tick(6);
    check(16'(link_led), 16'h0001);
  endtask
  task automatic t_delay_and_reset();
    int n;
    mac.xfer(OP_WRITE, PHY_ADDR, REG_DELAY, 16'h0002, rd);
    tick(4);
    check(16'({txc_dly, rxc_dly}), 16'h0001);
    mac.xfer(OP_READ, PHY_ADDR, REG_DELAY, 16'h0000, rd);
    check(rd, 16'h0002);
    // A pin reset must drop the link and restore the delay defaults.
    phy_rst_n = 1'b0;
    wait_val(W_LINK, 1'b0, n);
    check(16'({txc_dly, rxc_dly}), 16'h0003);
    phy_rst_n = 1'b1;
    wait_val(W_LINK, 1'b1, n);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    tick(2);
    // The transceiver stays in reset until the host has finished its own start-up.
    phy_rst_n = 1'b1;
    tick(4);
    t_defaults();
    t_link();
    t_act(1'b0);
    t_act(1'b1);
    t_eee();
    t_irq();
    t_delay_and_reset();
    complete_run();
  end
endmodule
